// ===== hw/icmc_top.sv
// Two-wire bus master with its APB register file, byte sequencer and interrupt.
// Assumes an APB master on pclk and open-drain pads resolved outside.
`default_nettype none
module icmc_top import icmc_pkg::*; #(
	parameter int QCYC = icmc_pkg::SCL_QUART_CYC
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Interrupt
	output logic             irq,
	// Open-drain pins
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe
);

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_WAIT  = 3'b001,
		S_START = 3'b010,
		S_BYTE  = 3'b011,
		S_ACK   = 3'b100,
		S_HOLD  = 3'b101,
		S_STOP  = 3'b110
	} icmc_state_t;

	icmc_bit_if bus ();

	logic [15:0]   ctrl_q, stat_q, mask_q;
	logic [31:0]   prdata_q;
	logic          pready_q, pslverr_q, irq_q, scl_oe_q, sda_oe_q;
	logic [7:0]    addr_q, txd_q, rxd_q, rd_len_q, rd_left_q, shift_q;
	logic          tx_valid_q, rx_valid_q, addr_pend_q, stop_req_q;
	logic          is_read_q, addr_phase_q, issued_q, cmd_valid_q, wbit_q, en_prev_q;
	icmc_bit_cmd_t cmd_q;
	icmc_state_t   state_q;
	logic [2:0]    bit_cnt_q;
	logic [15:0]   evt, wmask, w1c;
	logic          setup, wr, rd_done, master_en, loopback, backoff_dis;
	logic          byte_tx, byte_rx, no_ack;

	// Decodes a register offset; used by read data, error answer and writes.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : hit

	function automatic logic mapped(input logic [7:0] a);
		return hit(a, CTRL_OFS) | hit(a, STAT_OFS) | hit(a, MASK_OFS) | hit(a, ADDR_OFS) |
			hit(a, TXD_OFS) | hit(a, RXD_OFS) | hit(a, CMD_OFS);
	endfunction : mapped

	assign master_en   = ctrl_q[MASTER_EN_BIT];
	assign loopback    = ctrl_q[LOOPBACK_BIT];
	assign backoff_dis = ctrl_q[BACKOFF_BIT];
	assign setup       = psel & ~penable;
	assign wr          = psel & penable & pready_q & pwrite & ~pslverr_q;
	assign rd_done     = psel & penable & pready_q & ~pwrite & hit(paddr, RXD_OFS);
	assign wmask       = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign w1c         = (wr && hit(paddr, STAT_OFS)) ? (pwdata[15:0] & wmask & EVT_MASK) : 16'h0000;

	icmc_bus_mon u_mon (
		.pclk     (pclk),
		.presetn  (presetn),
		.scl_i    (scl_i),
		.sda_i    (sda_i),
		.loopback (loopback),
		.bus      (bus.mon)
	);

	icmc_bit_eng #(.QCYC(QCYC)) u_eng (
		.pclk    (pclk),
		.presetn (presetn),
		.bus     (bus.eng)
	);

	assign bus.cmd_valid = cmd_valid_q;
	assign bus.cmd       = cmd_q;
	assign bus.wbit      = wbit_q;
	// Dropping master mode mid-transfer releases both lines at once.
	assign bus.abort     = en_prev_q & ~master_en;

	// APB answer: decoded in the setup cycle, so every access has no wait state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~mapped(paddr);
			prdata_q  <= 32'h0000_0000;
			if (setup && !pwrite) begin
				unique case (1'b1)
					hit(paddr, CTRL_OFS): prdata_q <= {16'h0000, ctrl_q};
					hit(paddr, STAT_OFS): prdata_q <= {16'h0000, stat_q};
					hit(paddr, MASK_OFS): prdata_q <= {16'h0000, mask_q};
					hit(paddr, ADDR_OFS): prdata_q <= {24'h00_0000, addr_q};
					hit(paddr, TXD_OFS):  prdata_q <= {24'h00_0000, txd_q};
					hit(paddr, RXD_OFS):  prdata_q <= {24'h00_0000, rxd_q};
					hit(paddr, CMD_OFS):  prdata_q <= {16'h0000, rd_len_q, 8'h00};
					default:              prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Reserved control bits are not stored, so they read back as zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q    <= CTRL_RESET;
			mask_q    <= 16'h0000;
			en_prev_q <= 1'b0;
		end else begin
			en_prev_q <= master_en;
			if (wr && hit(paddr, CTRL_OFS)) begin
				ctrl_q <= (ctrl_q & ~wmask) | (pwdata[15:0] & wmask & CTRL_WMASK);
			end
			if (wr && hit(paddr, MASK_OFS)) begin
				mask_q <= (mask_q & ~wmask) | (pwdata[15:0] & wmask & EVT_MASK);
			end
		end
	end

	// Event vector in the same layout as the enable bits.
	always_comb begin
		evt                = 16'h0000;
		evt[XFER_DONE_BIT] = bus.stop_det;
		evt[NO_ACK_BIT]    = no_ack;
		evt[ARB_LOST_BIT]  = bus.arb_lost;
		evt[TX_BYTE_BIT]   = byte_tx;
		evt[RX_DATA_BIT]   = byte_rx;
	end

	// An event in the same cycle as its write-one-to-clear keeps the flag set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= 16'h0000;
		end else begin
			stat_q                <= (stat_q & ~w1c) | evt;
			stat_q[BUS_BUSY_BIT]  <= bus.bus_busy;
			stat_q[MBUSY_BIT]     <= state_q != S_IDLE;
			stat_q[RX_VALID_BIT]  <= rx_valid_q;
			stat_q[TX_EMPTY_BIT]  <= ~tx_valid_q;
			stat_q[MASTER_EN_BIT] <= 1'b0;
		end
	end

	// Each source needs its control enable and its mask bit; a cleared enable masks it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_q & ctrl_q & mask_q & EVT_MASK);
		end
	end

	// Pads: loopback keeps the block off the wires and feeds its drive back inside.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			scl_oe_q <= bus.scl_oe & ~loopback;
			sda_oe_q <= bus.sda_oe & ~loopback;
		end
	end

	// Data, address and command registers; a write in the same cycle wins over hardware consumption.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_q      <= 8'h00;
			txd_q       <= 8'h00;
			rd_len_q    <= 8'h00;
			tx_valid_q  <= 1'b0;
			addr_pend_q <= 1'b0;
			stop_req_q  <= 1'b0;
			rx_valid_q  <= 1'b0;
		end else begin
			if (wr && hit(paddr, ADDR_OFS) && pstrb[0] && master_en) begin
				addr_q      <= pwdata[7:0];
				addr_pend_q <= 1'b1;
			end else if (state_q == S_IDLE || state_q == S_HOLD) begin
				addr_pend_q <= 1'b0;
			end
			if (wr && hit(paddr, TXD_OFS) && pstrb[0]) begin
				txd_q      <= pwdata[7:0];
				tx_valid_q <= 1'b1;
			end else if (state_q == S_HOLD && !addr_pend_q) begin
				tx_valid_q <= 1'b0;
			end
			if (wr && hit(paddr, CMD_OFS)) begin
				if (pstrb[1]) begin
					rd_len_q <= pwdata[15:8];
				end
				if (pstrb[0]) begin
					stop_req_q <= pwdata[STOP_REQ_BIT];
				end
			end else if (state_q == S_STOP) begin
				stop_req_q <= 1'b0;
			end
			if (byte_rx) begin
				rx_valid_q <= 1'b1;
			end else if (rd_done) begin
				rx_valid_q <= 1'b0;
			end
		end
	end

	assign byte_tx = bus.done && state_q == S_ACK && (addr_phase_q || !is_read_q);
	assign byte_rx = bus.done && state_q == S_ACK && !addr_phase_q && is_read_q;
	assign no_ack  = byte_tx && bus.rbit;

	// Byte sequencer: one bit command in flight at a time.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q      <= S_IDLE;
			issued_q     <= 1'b0;
			cmd_valid_q  <= 1'b0;
			cmd_q        <= BIT_START;
			wbit_q       <= 1'b0;
			shift_q      <= 8'h00;
			bit_cnt_q    <= 3'd0;
			is_read_q    <= 1'b0;
			addr_phase_q <= 1'b0;
			rd_left_q    <= 8'h00;
			rxd_q        <= 8'h00;
		end else begin
			cmd_valid_q <= 1'b0;
			if (!master_en || bus.arb_lost) begin
				state_q  <= S_IDLE;
				issued_q <= 1'b0;
			end else begin
				unique case (state_q)
					S_IDLE: begin
						if (addr_pend_q) begin
							state_q <= S_WAIT;
						end
					end
					S_WAIT: begin
						if (backoff_dis || !bus.bus_busy) begin
							state_q <= S_START;
						end
					end
					S_START: begin
						if (!issued_q) begin
							cmd_q       <= BIT_START;
							cmd_valid_q <= 1'b1;
							issued_q    <= 1'b1;
						end else if (bus.done) begin
							issued_q     <= 1'b0;
							shift_q      <= addr_q;
							is_read_q    <= addr_q[0];
							addr_phase_q <= 1'b1;
							rd_left_q    <= rd_len_q;
							bit_cnt_q    <= 3'd7;
							state_q      <= S_BYTE;
						end
					end
					S_BYTE: begin
						if (!issued_q) begin
							cmd_q       <= (addr_phase_q || !is_read_q) ? BIT_WRITE : BIT_READ;
							wbit_q      <= shift_q[7];
							cmd_valid_q <= 1'b1;
							issued_q    <= 1'b1;
						end else if (bus.done) begin
							issued_q  <= 1'b0;
							shift_q   <= {shift_q[6:0], bus.rbit};
							bit_cnt_q <= bit_cnt_q - 3'd1;
							if (bit_cnt_q == 3'd0) begin
								state_q <= S_ACK;
							end
						end
					end
					S_ACK: begin
						if (!issued_q) begin
							// The last byte of a read is refused so the slave lets go of data.
							cmd_q       <= (addr_phase_q || !is_read_q) ? BIT_READ : BIT_WRITE;
							wbit_q      <= rd_left_q == 8'd1;
							cmd_valid_q <= 1'b1;
							issued_q    <= 1'b1;
						end else if (bus.done) begin
							issued_q  <= 1'b0;
							bit_cnt_q <= 3'd7;
							if (byte_tx && bus.rbit) begin
								state_q <= S_STOP;
							end else if (addr_phase_q && is_read_q) begin
								addr_phase_q <= 1'b0;
								state_q      <= (rd_left_q == 8'd0) ? S_STOP : S_BYTE;
							end else if (byte_rx) begin
								rxd_q     <= shift_q;
								rd_left_q <= rd_left_q - 8'd1;
								state_q   <= (rd_left_q == 8'd1) ? S_HOLD : S_BYTE;
							end else begin
								addr_phase_q <= 1'b0;
								state_q      <= S_HOLD;
							end
						end
					end
					S_HOLD: begin
						// Clock is held low here until software supplies data, a new address or a stop; after a read the stop follows unless an address is pending.
						if (addr_pend_q) begin
							state_q <= S_START;
						end else if (tx_valid_q && !is_read_q) begin
							shift_q <= txd_q;
							state_q <= S_BYTE;
						end else if (stop_req_q || is_read_q) begin
							state_q <= S_STOP;
						end
					end
					S_STOP: begin
						if (!issued_q) begin
							cmd_q       <= BIT_STOP;
							cmd_valid_q <= 1'b1;
							issued_q    <= 1'b1;
						end else if (bus.done) begin
							issued_q <= 1'b0;
							state_q  <= S_IDLE;
						end
					end
					default: state_q <= S_IDLE;
				endcase
			end
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign irq     = irq_q;
	assign scl_oe  = scl_oe_q;
	assign sda_oe  = sda_oe_q;
	// Open-drain: the pad only ever pulls low, gated by the enables above.
	assign scl_o   = 1'b0;
	assign sda_o   = 1'b0;
endmodule : icmc_top
`default_nettype wire

// ===== common/icmc_pkg.sv
// Constants, register map and shared types of the two-wire bus master block.
// Assumes a 125 MHz APB clock; all offsets are byte addresses of 32-bit words.
// Operation
// - Bit 8 enables stop-detected transfer interrupt.
// - Bit 7 enables no-acknowledge interrupt.
// - Bit 6 enables arbitration-lost interrupt.
// - Bit 5 enables byte-transmitted interrupt.
// - Bit 4 enables data-received interrupt.
// - Bit 2 loops own outputs to inputs.
// - Bit 1 set competes despite foreign start.
// - Bit 1 clear waits for free bus.
// - Bit 0 enables master mode.
// - Control register 16 bits, read/write, resets zero.
// - Transfer end sets the transfer-done flag.
// - Lost arbitration sets the arbitration-lost flag.
`default_nettype none
package icmc_pkg;
	localparam logic [7:0]  CTRL_OFS      = 8'h00;
	localparam logic [7:0]  STAT_OFS      = 8'h04;
	localparam logic [7:0]  MASK_OFS      = 8'h08;
	localparam logic [7:0]  ADDR_OFS      = 8'h0C;
	localparam logic [7:0]  TXD_OFS       = 8'h10;
	localparam logic [7:0]  RXD_OFS       = 8'h14;
	localparam logic [7:0]  CMD_OFS       = 8'h18;
	localparam int          XFER_DONE_BIT = 8;
	localparam int          NO_ACK_BIT    = 7;
	localparam int          ARB_LOST_BIT  = 6;
	localparam int          TX_BYTE_BIT   = 5;
	localparam int          RX_DATA_BIT   = 4;
	localparam int          LOOPBACK_BIT  = 2;
	localparam int          BACKOFF_BIT   = 1;
	localparam int          MASTER_EN_BIT = 0;
	localparam int          BUS_BUSY_BIT  = 10;
	localparam int          MBUSY_BIT     = 9;
	localparam int          RX_VALID_BIT  = 3;
	localparam int          TX_EMPTY_BIT  = 2;
	localparam int          STOP_REQ_BIT  = 0;
	localparam logic [15:0] CTRL_RESET    = 16'h0000;
	localparam logic [15:0] CTRL_WMASK    = 16'h01F7;
	localparam logic [15:0] EVT_MASK      = 16'h01F0;
	localparam int          CLK_PERIOD_NS = 8;
	localparam int          SCL_QUART_NS  = 20;
	localparam int          SCL_QUART_CYC = (SCL_QUART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		BIT_START = 2'b00,
		BIT_STOP  = 2'b01,
		BIT_WRITE = 2'b10,
		BIT_READ  = 2'b11
	} icmc_bit_cmd_t;
endpackage : icmc_pkg
`default_nettype wire

// ===== common/icmc_bit_if.sv
// Carries bit commands, line levels and bus conditions between the block's modules.
// Assumes all members live in the pclk domain.
`default_nettype none
interface icmc_bit_if;
	import icmc_pkg::*;
	logic          scl_line;
	logic          sda_line;
	logic          start_det;
	logic          stop_det;
	logic          bus_busy;
	logic          cmd_valid;
	icmc_bit_cmd_t cmd;
	logic          wbit;
	logic          abort;
	logic          done;
	logic          rbit;
	logic          arb_lost;
	logic          scl_oe;
	logic          sda_oe;

	modport seq (input scl_line, sda_line, start_det, stop_det, bus_busy, done, rbit, arb_lost, scl_oe, sda_oe,
		output cmd_valid, cmd, wbit, abort);
	modport eng (input cmd_valid, cmd, wbit, abort, scl_line, sda_line, output done, rbit, arb_lost, scl_oe, sda_oe);
	modport mon (input scl_oe, sda_oe, output scl_line, sda_line, start_det, stop_det, bus_busy);
endinterface : icmc_bit_if
`default_nettype wire

// ===== hw/icmc_bus_mon.sv
// Line synchroniser, loopback selection and start/stop detection.
// Assumes the pins are asynchronous to pclk.
`default_nettype none
module icmc_bus_mon import icmc_pkg::*; (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Pins and mode
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic loopback,
	// Shared bus view
	icmc_bit_if.mon   bus
);
	logic scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;
	logic scl_prev_q, sda_prev_q, start_q, stop_q, busy_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
		end else begin
			scl_s1_q <= scl_i;
			scl_s2_q <= scl_s1_q;
			sda_s1_q <= sda_i;
			sda_s2_q <= sda_s1_q;
		end
	end

	// Loopback takes the driven level straight back, so no synchroniser delay applies there.
	assign bus.scl_line = loopback ? ~bus.scl_oe : scl_s2_q;
	assign bus.sda_line = loopback ? ~bus.sda_oe : sda_s2_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			start_q    <= 1'b0;
			stop_q     <= 1'b0;
			busy_q     <= 1'b0;
		end else begin
			scl_prev_q <= bus.scl_line;
			sda_prev_q <= bus.sda_line;
			start_q    <= scl_prev_q & bus.scl_line & sda_prev_q & ~bus.sda_line;
			stop_q     <= scl_prev_q & bus.scl_line & ~sda_prev_q & bus.sda_line;
			if (start_q) begin
				busy_q <= 1'b1;
			end else if (stop_q) begin
				busy_q <= 1'b0;
			end
		end
	end

	assign bus.start_det = start_q;
	assign bus.stop_det  = stop_q;
	assign bus.bus_busy  = busy_q;
endmodule : icmc_bus_mon
`default_nettype wire

// ===== hw/icmc_bit_eng.sv
// Bit engine: start, stop, write bit and read bit in four quarter phases.
// Assumes commands arrive only while it is idle; honours clock stretching.
`default_nettype none
module icmc_bit_eng import icmc_pkg::*; #(
	parameter int QCYC = icmc_pkg::SCL_QUART_CYC
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Shared bus view
	icmc_bit_if.eng   bus
);
	logic          busy_q, wbit_q, done_q, rbit_q, arb_q, scl_oe_q, sda_oe_q;
	icmc_bit_cmd_t cmd_q;
	logic [1:0]    phase_q;
	logic [7:0]    cnt_q;
	logic [1:0]    lvl;
	logic          stall;

	// Returns {scl pulled low, sda pulled low} for one phase.
	function automatic logic [1:0] drive(input icmc_bit_cmd_t c, input logic [1:0] p, input logic w);
		logic [1:0] r;
		r = 2'b00;
		unique case (c)
			BIT_START: r = (p == 2'd0) ? 2'b00 : (p == 2'd1) ? 2'b01 : 2'b11;
			BIT_STOP:  r = (p == 2'd0) ? 2'b11 : (p == 2'd1) ? 2'b01 : 2'b00;
			BIT_WRITE: r = {(p == 2'd0) || (p == 2'd3), ~w};
			BIT_READ:  r = {(p == 2'd0) || (p == 2'd3), 1'b0};
		endcase
		return r;
	endfunction : drive

	assign lvl   = drive(cmd_q, phase_q, wbit_q);
	// A released clock that still reads low is being stretched by a slave.
	assign stall = ~scl_oe_q & ~bus.scl_line;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q   <= 1'b0;
			cmd_q    <= BIT_START;
			wbit_q   <= 1'b0;
			phase_q  <= 2'd0;
			cnt_q    <= 8'd0;
			done_q   <= 1'b0;
			rbit_q   <= 1'b0;
			arb_q    <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			arb_q  <= 1'b0;
			if (bus.abort) begin
				busy_q   <= 1'b0;
				scl_oe_q <= 1'b0;
				sda_oe_q <= 1'b0;
			end else if (!busy_q) begin
				if (bus.cmd_valid) begin
					busy_q  <= 1'b1;
					cmd_q   <= bus.cmd;
					wbit_q  <= bus.wbit;
					phase_q <= 2'd0;
					cnt_q   <= 8'd0;
				end
			end else begin
				{scl_oe_q, sda_oe_q} <= lvl;
				if (!stall) begin
					if (cnt_q == 8'(QCYC - 1)) begin
						cnt_q   <= 8'd0;
						phase_q <= phase_q + 2'd1;
						if (phase_q == 2'd2) begin
							rbit_q <= bus.sda_line;
						end
						// A released one that reads zero means another master won.
						if (phase_q == 2'd2 && cmd_q == BIT_WRITE && wbit_q && !bus.sda_line) begin
							arb_q    <= 1'b1;
							busy_q   <= 1'b0;
							scl_oe_q <= 1'b0;
							sda_oe_q <= 1'b0;
						end else if (phase_q == 2'd3) begin
							done_q <= 1'b1;
							busy_q <= 1'b0;
						end
					end else begin
						cnt_q <= cnt_q + 8'd1;
					end
				end
			end
		end
	end

	assign bus.done     = done_q;
	assign bus.rbit     = rbit_q;
	assign bus.arb_lost = arb_q;
	assign bus.scl_oe   = scl_oe_q;
	assign bus.sda_oe   = sda_oe_q;
endmodule : icmc_bit_eng
`default_nettype wire

// ===== verification/icmc_chk.sv
// Checker of the control register, APB timing, interrupt and pad enables.
// Assumes a bind to icmc_top and the sight of its ports only.
`default_nettype none
module icmc_chk
	import icmc_pkg::*;
#(
	parameter int QCYC = 3
) (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Interrupt and pads
	input wire logic        irq,
	input wire logic        scl_oe,
	input wire logic        sda_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        wr_acc;
	logic [15:0] ctrl_q;
	assign wr_acc = psel && penable && pready && pwrite;
	// A shadow of the control register; reserved bits are never stored.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 16'h0000;
		end else if (wr_acc && paddr == CTRL_OFS) begin
			ctrl_q <= pwdata[15:0] & 16'h01f7;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready_next; psel && !penable |=> pready; endproperty
	a_ready_next: assert property (p_ready_next) else $error("no pready after setup");
	property p_ready_cause; pready |-> $past(psel && !penable); endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("pready without setup");
	property p_ready_one; pready |=> !pready; endproperty
	a_ready_one: assert property (p_ready_one) else $error("pready too long");
	property p_rd_ctrl; psel && penable && pready && !pwrite && paddr == CTRL_OFS |-> prdata == {16'h0000, ctrl_q};
	endproperty
	a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
	property p_unmapped; psel && penable && pready && paddr > CMD_OFS |-> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
	property p_irq_en; $past(ctrl_q[8:4]) == 5'h00 |-> !irq; endproperty
	a_irq_en: assert property (p_irq_en) else $error("irq with sources off");
	property p_irq_hold; irq && !$past(wr_acc) |=> irq; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped unprompted");
	property p_loop; ctrl_q[LOOPBACK_BIT] && $past(ctrl_q[LOOPBACK_BIT]) |-> !scl_oe && !sda_oe; endproperty
	a_loop: assert property (p_loop) else $error("pads driven in loopback");
	property p_release; !ctrl_q[MASTER_EN_BIT] |-> ##[0:8] (!scl_oe && !sda_oe); endproperty
	a_release: assert property (p_release) else $error("pads held with master off");
	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
	c_drive: cover property (scl_oe && ctrl_q[MASTER_EN_BIT]);
endmodule : icmc_chk
bind icmc_top icmc_chk #(.QCYC(QCYC)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.irq(irq), .scl_oe(scl_oe), .sda_oe(sda_oe));
`default_nettype wire

// ===== verification/icmc_slave.sv
// Behavioural bus slave: acknowledges its own address and each byte after it.
// Assumes resolved lines with pull-ups; it serves no reads.
`default_nettype none
module icmc_slave #(
	parameter logic [6:0] DEV_ADDR = 7'h2a
) (
	// Resolved lines
	input  wire logic scl,
	input  wire logic sda,
	// Pull on the data line
	output var logic  sda_pull
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] shift_q;
	int         n_bits = 0;
	logic       sel_q = 1'b0;
	logic       first_q = 1'b0;
	initial sda_pull = 1'b0;
	// A data edge while the clock line is high is a start or a stop.
	always @(sda) begin
		if (scl) begin
			n_bits = 0;
			first_q = !sda;
			sel_q = sel_q && !sda;
		end
	end
	always @(posedge scl) begin
		shift_q = {shift_q[6:0], sda};
		n_bits++;
	end
	// The pull changes only while the clock is low, so it never fakes a stop.
	always @(negedge scl) begin
		if (n_bits == 8) begin
			if (first_q) sel_q = shift_q[7:1] == DEV_ADDR;
			first_q = 1'b0;
			sda_pull = sel_q;
		end else begin
			sda_pull = 1'b0;
			if (n_bits == 9) n_bits = 0;
		end
	end
endmodule : icmc_slave
`default_nettype wire

// ===== verification/i2c_master_control_bench.sv
// Bench of the bus master: register map, interrupts, transfers and loopback.
// Assumes the slave model on pulled-up lines at address 7'h2a.
`default_nettype none
module i2c_master_control_bench import icmc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, irq, scl_oe, sda_oe, sda_pull, scl_w, sda_w, err;
	logic        fgn_pull = 1'b0;
	logic [15:0] c, m;
	int          n_errors = 0;
	int          check_count = 0;
	int          seed = 32'he4ef;
	always #4 pclk = ~pclk;
	assign scl_w = !scl_oe;
	assign sda_w = !(sda_oe || sda_pull || fgn_pull);
	icmc_top #(.QCYC(3)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe));
	icmc_slave slv_u (.scl(scl_w), .sda(sda_w), .sda_pull(sda_pull));
	function automatic logic irq_exp(input logic [15:0] s, input logic [15:0] ct, input logic [15:0] mk);
		return |(s & ct & mk & 16'h01f0);
	endfunction : irq_exp
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test
	// The request stands until pready is seen at an edge; read data is taken there.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wait_irq();
		int t;
		t = 0;
		while (irq !== 1'b1 && t < 4000) begin
			@(posedge pclk);
			t++;
		end
		check("irq raised", 32'(irq), 32'h0000_0001);
	endtask : wait_irq
	initial begin
		#200_000;
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, CTRL_OFS, 32'h0000_0000);
		check("ctrl reset", rd, 32'h0000_0000);
		apb(1'b0, 8'h1c, 32'h0000_0000);
		check("unmapped err", 32'(err), 32'h0000_0001);
		check("unmapped data", rd, 32'h0000_0000);
		// Random writes with reserved bits clear read back unchanged.
		for (int i = 0; i < 8; i++) begin
			c = 16'($random(seed)) & 16'h01f7;
			apb(1'b1, CTRL_OFS, {16'h0000, c});
			apb(1'b0, CTRL_OFS, 32'h0000_0000);
			check("ctrl", rd, {16'h0000, c});
		end
		apb(1'b1, MASK_OFS, 32'h0000_01f0);
		apb(1'b1, CTRL_OFS, 32'h0000_0021);
		apb(1'b1, TXD_OFS, 32'h0000_005a);
		apb(1'b1, ADDR_OFS, 32'h0000_0054);
		wait_irq();
		apb(1'b0, STAT_OFS, 32'h0000_0000);
		check("tx byte", rd & 32'h0000_00a0, 32'h0000_0020);
		apb(1'b1, CTRL_OFS, 32'h0000_0101);
		apb(1'b1, STAT_OFS, 32'h0000_01f0);
		apb(1'b1, CMD_OFS, 32'h0000_0001);
		wait_irq();
		apb(1'b0, STAT_OFS, 32'h0000_0000);
		check("xfer done", rd & 32'h0000_0180, 32'h0000_0100);
		for (int i = 0; i < 6; i++) begin
			c = 16'($random(seed)) & 16'h01f1;
			m = 16'($random(seed)) & 16'h01f0;
			apb(1'b1, CTRL_OFS, {16'h0000, c});
			apb(1'b1, MASK_OFS, {16'h0000, m});
			apb(1'b0, STAT_OFS, 32'h0000_0000);
			check("irq mix", 32'(irq), 32'(irq_exp(rd[15:0], c, m)));
		end
		apb(1'b1, CTRL_OFS, 32'h0000_0101);
		apb(1'b1, MASK_OFS, 32'h0000_01f0);
		apb(1'b0, STAT_OFS, 32'h0000_0000);
		check("irq on", 32'(irq), 32'h0000_0001);
		apb(1'b1, STAT_OFS, 32'h0000_01f0);
		apb(1'b0, STAT_OFS, 32'h0000_0000);
		check("cleared", {rd[31:9], rd[8:4] | {4'h0, irq}, rd[3:0]} & 32'h0000_01f0, 32'h0000_0000);
		// A foreign address is not answered, so the no-ack source fires.
		apb(1'b1, CTRL_OFS, 32'h0000_0081);
		apb(1'b1, ADDR_OFS, 32'h0000_0022);
		wait_irq();
		apb(1'b0, STAT_OFS, 32'h0000_0000);
		check("no ack", rd & 32'h0000_0080, 32'h0000_0080);
		apb(1'b1, STAT_OFS, 32'h0000_01f0);
		// In loopback the slave is cut off, so even its own address is refused.
		apb(1'b1, CTRL_OFS, 32'h0000_0085);
		apb(1'b1, ADDR_OFS, 32'h0000_0054);
		wait_irq();
		apb(1'b0, STAT_OFS, 32'h0000_0000);
		check("loop no ack", rd & 32'h0000_0080, 32'h0000_0080);
		// A foreign start keeps the bus busy; with back-off disabled the block competes and loses.
		repeat (64) @(posedge pclk);
		fgn_pull <= 1'b1;
		apb(1'b1, CTRL_OFS, 32'h0000_0043);
		apb(1'b1, STAT_OFS, 32'h0000_01f0);
		apb(1'b1, ADDR_OFS, 32'h0000_0054);
		wait_irq();
		apb(1'b0, STAT_OFS, 32'h0000_0000);
		check("arb lost", rd & 32'h0000_0440, 32'h0000_0440);
		// With back-off enabled it must stay off the wires until the foreign stop.
		apb(1'b1, STAT_OFS, 32'h0000_01f0);
		apb(1'b1, CTRL_OFS, 32'h0000_0081);
		apb(1'b1, ADDR_OFS, 32'h0000_0022);
		repeat (64) @(posedge pclk);
		check("backoff", 32'({scl_oe, irq}), 32'h0000_0000);
		fgn_pull <= 1'b0;
		wait_irq();
		apb(1'b1, CTRL_OFS, 32'h0000_0000);
		end_of_test();
	end
endmodule : i2c_master_control_bench
`default_nettype wire
